/* File: core/imc_core.sv */
// Purpose: register-driven two-wire bus master behind an APB slave
// Assumes: one clock; pins are open drain, resolved outside
// Notes:   one command held at a time; software polls the pending bit
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "imc_regs.svh"

module imc_core
	import imc_pkg::*;
#(
	parameter logic [15:0] LOW_STD   = `IMC_LCNT_STD,
	parameter logic [15:0] HIGH_FAST = `IMC_HCNT_FAST,
	parameter logic [15:0] LOW_FAST  = `IMC_LCNT_FAST
)(
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rstn,
	// apb slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [15:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output var  logic [31:0]  prdata,
	output var  logic         pready,
	output var  logic         pslverr,
	// interrupt
	output var  logic         irq,
	// two-wire pins
	input  wire logic         sclIn,
	input  wire logic         sdaIn,
	output var  imc_pad_out_t pads
);

// ----------------------------------------
// helpers
// ----------------------------------------
function automatic logic [16:0] highTicks(input logic [1:0] spd, input logic [15:0] hc);
	if (spd == `IMC_SPD_FAST)
		highTicks = {1'b0, HIGH_FAST} + `IMC_HIGH_ADD;
	else
		highTicks = {1'b0, hc} + `IMC_HIGH_ADD;
endfunction

function automatic logic [16:0] lowTicks(input logic [1:0] spd);
	if (spd == `IMC_SPD_FAST)
		lowTicks = {1'b0, LOW_FAST} + `IMC_LOW_ADD;
	else
		lowTicks = {1'b0, LOW_STD} + `IMC_LOW_ADD;
endfunction

function automatic logic isMapped(input logic [15:0] a);
	case (a)
		`IMC_CTRL_OFS, `IMC_TAR_OFS, `IMC_RSVD_OFS, `IMC_DATA_OFS,
		`IMC_HCNT_OFS, `IMC_STAT_OFS, `IMC_CLR_OFS, `IMC_INTEN_OFS,
		`IMC_DIV_OFS, `IMC_IFEN_OFS: isMapped = 1'b1;
		default: isMapped = 1'b0;
	endcase
endfunction

// ----------------------------------------
// state
// ----------------------------------------
localparam imc_core_state_t RST = '{
	sclSync:   2'h3,
	sdaSync:   2'h3,
	rsv6:      1'b1,
	restartEn: 1'b1,
	speed:     `IMC_SPD_FAST,
	masterEn:  1'b1,
	tar:       `IMC_TAR_RST,
	rxData:    `IMC_DATA_RST,
	pend:      1'b0,
	pendRead:  1'b0,
	pendSbyte: 1'b0,
	pendData:  8'h00,
	curRead:   1'b0,
	curData:   8'h00,
	hcnt:      `IMC_HCNT_RST,
	ifEn:      1'b0,
	div:       `IMC_DIV_RST,
	divCnt:    16'h0000,
	status:    7'h00,
	intEn:     7'h00,
	st:        ST_IDLE,
	phase:     PH_ADDR,
	cnt:       17'h00000,
	shift:     9'h1ff,
	bitIdx:    4'h0,
	sclLow:    1'b0,
	sdaLow:    1'b0,
	prdata:    32'h00000000
};

imc_core_state_t s;
imc_core_state_t n;
logic            apbWr;

assign apbWr = psel & penable & pwrite;

// ----------------------------------------
// next state
// ----------------------------------------
always_comb
begin
	logic        tick;
	logic        step;
	logic        held;
	logic        contOk;
	logic        rdData;
	logic [16:0] lo;
	logic [16:0] hi;
	logic [8:0]  nsh;
	logic [8:0]  ld;
	logic [3:0]  nIdx;
	logic [6:0]  setBits;
	logic [6:0]  clrBits;
	tick    = 1'b0;
	held    = 1'b0;
	step    = 1'b0;
	setBits = 7'h00;
	clrBits = 7'h00;
	n       = s;
	lo      = lowTicks(s.speed) - 17'h00001;
	hi      = highTicks(s.speed, s.hcnt) - 17'h00001;
	nsh     = {s.shift[7:0], s.sdaSync[1]};
	nIdx    = s.bitIdx + 4'h1;
	rdData  = s.curRead && (s.phase == PH_DATA);
	contOk  = s.pend && s.ifEn && s.masterEn && !s.pendSbyte && s.restartEn;
	ld      = s.pendRead ? 9'h1ff : {s.pendData, 1'b1};

	n.sclSync = {s.sclSync[0], sclIn};
	n.sdaSync = {s.sdaSync[0], sdaIn};

	// read data is latched in setup so it is steady through access
	if (psel && !penable && !pwrite)
	begin
		case (paddr)
			`IMC_CTRL_OFS:  n.prdata = {25'h0, s.rsv6, s.restartEn, 2'h0, s.speed,
				s.masterEn};
			`IMC_TAR_OFS:   n.prdata = {25'h0, s.tar};
			`IMC_DATA_OFS:  n.prdata = {24'h0, s.rxData};
			`IMC_HCNT_OFS:  n.prdata = {16'h0, s.hcnt};
			`IMC_STAT_OFS:  n.prdata = {25'h0, s.status};
			`IMC_INTEN_OFS: n.prdata = {25'h0, s.intEn};
			`IMC_DIV_OFS:   n.prdata = {16'h0, s.div};
			`IMC_IFEN_OFS:  n.prdata = {29'h0, !s.st[0], s.pend, s.ifEn};
			default:        n.prdata = 32'h00000000;
		endcase
	end

	if (apbWr)
	begin
		case (paddr)
			`IMC_CTRL_OFS:
			begin
				if (!s.ifEn)
				begin
					n.rsv6      = pwdata[6];
					n.restartEn = pwdata[5];
					n.speed     = pwdata[2:1];
					n.masterEn  = pwdata[0];
				end
			end
			`IMC_TAR_OFS:
			begin
				if (!s.ifEn)
					n.tar = pwdata[6:0];
			end
			`IMC_DATA_OFS:
			begin
				// no queue: a command written while one is pending is dropped
				if (s.ifEn && s.masterEn && !s.pend)
				begin
					n.pend      = 1'b1;
					n.pendRead  = pwdata[`IMC_CMD_READ_BIT];
					n.pendSbyte = pwdata[`IMC_CMD_SBYTE_BIT];
					n.pendData  = pwdata[7:0];
				end
			end
			`IMC_HCNT_OFS:
			begin
				if (!s.ifEn)
					n.hcnt = (pwdata[15:0] < `IMC_HCNT_MIN) ? `IMC_HCNT_MIN
						: pwdata[15:0];
			end
			`IMC_CLR_OFS:   clrBits = pwdata[6:0];
			`IMC_INTEN_OFS: n.intEn = pwdata[6:0];
			`IMC_DIV_OFS:   n.div = pwdata[15:0];
			`IMC_IFEN_OFS:  n.ifEn = pwdata[0];
			default: ;
		endcase
	end

	// i2c clock period enable
	if (s.divCnt >= s.div)
	begin
		n.divCnt = 16'h0000;
		tick     = 1'b1;
	end
	else
		n.divCnt = s.divCnt + 16'h0001;

	// a slave holding SCL low pauses the high phases
	held = (s.st == ST_START_A || s.st == ST_BIT_HI || s.st == ST_STOP_HI)
		&& !s.sclSync[1];
	if (tick && !held)
	begin
		if (s.cnt == 17'h00000)
			step = 1'b1;
		else
			n.cnt = s.cnt - 17'h00001;
	end

	case (s.st)
		ST_IDLE:
		begin
			if (s.pend && s.ifEn && s.masterEn)
			begin
				n.pend = 1'b0;
				if (s.pendSbyte && !s.restartEn)
					setBits[`IMC_ST_ABORT_BIT] = 1'b1;
				else
				begin
					n.curRead = s.pendRead;
					n.curData = s.pendData;
					n.phase   = s.pendSbyte ? PH_SBYTE : PH_ADDR;
					n.st      = ST_START_A;
					n.cnt     = hi;
				end
			end
		end
		ST_RESTART:
		begin
			if (step)
			begin
				n.sclLow = 1'b0;
				n.st     = ST_START_A;
				n.cnt    = hi;
			end
		end
		ST_START_A:
		begin
			if (step)
			begin
				n.sdaLow = 1'b1;
				n.st     = ST_START_B;
				n.cnt    = hi;
			end
		end
		ST_START_B:
		begin
			if (step)
			begin
				n.shift  = (s.phase == PH_SBYTE) ? {`IMC_START_BYTE, 1'b1}
					: {s.tar, s.curRead, 1'b1};
				n.sdaLow = !n.shift[8];
				n.bitIdx = 4'h0;
				n.sclLow = 1'b1;
				n.st     = ST_BIT_LO;
				n.cnt    = lo;
			end
		end
		ST_BIT_LO:
		begin
			if (step)
			begin
				n.sclLow = 1'b0;
				n.st     = ST_BIT_HI;
				n.cnt    = hi;
			end
		end
		ST_BIT_HI:
		begin
			if (step)
			begin
				n.shift  = nsh;
				n.bitIdx = nIdx;
				n.sclLow = 1'b1;
				n.cnt    = lo;
				n.st     = ST_BIT_LO;
				if (nIdx < 4'h9)
				begin
					// on reads the master acks only when another read follows
					if (rdData)
						n.sdaLow = (nIdx == 4'h8) && s.pendRead && contOk;
					else
						n.sdaLow = !nsh[8];
				end
				else
				begin
					n.bitIdx = 4'h0;
					n.sdaLow = 1'b1;
					n.st     = ST_STOP_LO;
					if (s.phase == PH_SBYTE)
					begin
						n.phase  = PH_ADDR;
						n.sdaLow = 1'b0;
						n.st     = ST_RESTART;
					end
					else if (s.phase == PH_ADDR)
					begin
						if (nsh[0])
							setBits[`IMC_ST_NACK_BIT] = 1'b1;
						else
						begin
							n.phase  = PH_DATA;
							n.shift  = s.curRead ? 9'h1ff : {s.curData, 1'b1};
							n.sdaLow = !s.curRead && !s.curData[7];
							n.st     = ST_BIT_LO;
						end
					end
					else
					begin
						setBits[`IMC_ST_DONE_BIT] = 1'b1;
						if (s.curRead)
							n.rxData = nsh[8:1];
						else if (nsh[0])
							setBits[`IMC_ST_NACK_BIT] = 1'b1;
						// without restarts every byte closes with stop
						if (!nsh[0] && contOk)
						begin
							n.pend    = 1'b0;
							n.curData = s.pendData;
							n.curRead = s.pendRead;
							if (s.pendRead == s.curRead)
							begin
								n.shift  = ld;
								n.sdaLow = !ld[8];
								n.st     = ST_BIT_LO;
							end
							else
							begin
								n.phase  = PH_ADDR;
								n.sdaLow = 1'b0;
								n.st     = ST_RESTART;
							end
						end
					end
				end
			end
		end
		ST_STOP_LO:
		begin
			if (step)
			begin
				n.sclLow = 1'b0;
				n.st     = ST_STOP_HI;
				n.cnt    = hi;
			end
		end
		ST_STOP_HI:
		begin
			if (step)
			begin
				n.sdaLow = 1'b0;
				n.st     = ST_STOP_END;
				n.cnt    = hi;
			end
		end
		ST_STOP_END:
		begin
			if (step)
				n.st = ST_IDLE;
		end
		default:
		begin
			n.st     = ST_IDLE;
			n.sclLow = 1'b0;
			n.sdaLow = 1'b0;
		end
	endcase

	// set wins over a clear in the same cycle
	n.status = (s.status & ~clrBits) | setBits;
end

always_ff @(posedge clock or negedge rstn)
begin
	if (!rstn)
		s <= RST;
	else
		s <= n;
end

// ----------------------------------------
// outputs
// ----------------------------------------
assign prdata      = s.prdata;
assign pready      = 1'b1;
assign pslverr     = psel & penable & !isMapped(paddr);
assign irq         = |(s.status & s.intEn);
assign pads.sclOut = 1'b0;
assign pads.sclOeN = !s.sclLow;
assign pads.sdaOut = 1'b0;
assign pads.sdaOeN = !s.sdaLow;

// ----------------------------------------
// checks
// ----------------------------------------
default clocking cb @(posedge clock); endclocking
default disable iff (!rstn);

a_ctrl_locked: assert property (
	apbWr && paddr == `IMC_CTRL_OFS && s.ifEn
	|=> $stable({s.rsv6, s.restartEn, s.speed, s.masterEn}))
	else $error("control changed while interface enabled");

a_tar_locked: assert property (
	apbWr && paddr == `IMC_TAR_OFS && s.ifEn |=> $stable(s.tar))
	else $error("target changed while interface enabled");

a_speed_taken: assert property (
	apbWr && paddr == `IMC_CTRL_OFS && !s.ifEn
	|=> s.speed == $past(pwdata[2:1]) && s.masterEn == $past(pwdata[0]))
	else $error("control write while disabled not stored");

a_hcnt_floor: assert property (
	s.hcnt >= 16'h0006)
	else $error("standard high count below floor");

a_hcnt_locked: assert property (
	apbWr && paddr == `IMC_HCNT_OFS && s.ifEn |=> $stable(s.hcnt))
	else $error("high count changed while interface enabled");

a_abort_flag: assert property (
	s.st == ST_IDLE && s.pend && s.ifEn && s.masterEn && s.pendSbyte && !s.restartEn
	|=> s.status[6] && s.st == ST_IDLE && !s.pend)
	else $error("start byte not aborted without restarts");

a_no_restart: assert property (
	s.st == ST_BIT_HI && !s.restartEn |=> s.st != ST_RESTART)
	else $error("repeated start with restarts disabled");

a_high_time: assert property (
	$rose(s.st == ST_BIT_HI) && s.speed != 2'h2 |-> s.cnt == {1'b0, s.hcnt} + 17'h00007)
	else $error("standard high period not count plus 8");

a_addr_byte: assert property (
	$past(s.st) == ST_START_B && s.st == ST_BIT_LO && s.phase == PH_ADDR
	|-> s.shift[8:1] == {s.tar, s.curRead} && s.sclLow)
	else $error("address byte not target plus direction");

a_sda_steady: assert property (
	s.st == ST_BIT_HI && $past(s.st) == ST_BIT_HI |-> $stable(s.sdaLow))
	else $error("data line moved while clock high");

endmodule

`default_nettype wire

/* File: core/imc_regs.svh */
// Purpose: register map and timing defaults of the two-wire master
// Assumes: byte addresses on a 32-bit APB
// Notes:   counts are in I2C clock periods
// How it works
// - restart permit 0 forbids repeated starts; resets to 1
// - without restarts each byte ends with stop, next starts afresh
// - start byte request without restarts is dropped, abort flag bit 6 set
// - speed 01 standard 100 kbit/s, 10 fast 400 kbit/s, others reserved
// - speed field changes only while interface enable is 0
// - master enable bit 0, reset 1, changes only while interface disabled
// - control and target writes ignored while interface enabled
// - 7-bit target in bits 6-0 used; bits 9-7 read zero
// - command bit 8 written 0 queues a write, 1 a read
// - data bits 7-0 carry byte sent, or byte received on reads
// - standard high count writes dropped unless interface disabled
// - standard high count below 6 loads 6
// - standard SCL high lasts (count plus 8) I2C clock periods
// - resets: high count 0064h, data 0000h, target 0055h
`ifndef IMC_REGS_SVH
`define IMC_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define IMC_CTRL_OFS  16'h3800
`define IMC_TAR_OFS   16'h3804
`define IMC_RSVD_OFS  16'h3808
`define IMC_DATA_OFS  16'h3810
`define IMC_HCNT_OFS  16'h3814
`define IMC_STAT_OFS  16'h382c
`define IMC_CLR_OFS   16'h3830
`define IMC_INTEN_OFS 16'h3834
`define IMC_DIV_OFS   16'h3838
`define IMC_IFEN_OFS  16'h386c

// ----------------------------------------
// fields and values
// ----------------------------------------
`define IMC_CMD_READ_BIT  8
`define IMC_CMD_SBYTE_BIT 10
`define IMC_ST_NACK_BIT   0
`define IMC_ST_DONE_BIT   1
`define IMC_ST_ABORT_BIT  6
`define IMC_SPD_FAST      2'h2
`define IMC_START_BYTE    8'h01
`define IMC_TAR_RST       7'h55
`define IMC_DATA_RST      8'h00
`define IMC_HCNT_RST      16'h0064
`define IMC_HCNT_MIN      16'h0006
`define IMC_HIGH_ADD      17'h00008
`define IMC_LOW_ADD       17'h00001
`define IMC_LCNT_STD      16'h0076
`define IMC_HCNT_FAST     16'h000f
`define IMC_LCNT_FAST     16'h0021
`define IMC_DIV_RST       16'h0000

`endif

/* File: core/imc_pkg.sv */
// Purpose: types of the two-wire master
// Assumes: nothing
// Notes:   one-hot codes written out
package imc_pkg;

	typedef enum logic [8:0] {
		ST_IDLE     = 9'h001,
		ST_RESTART  = 9'h002,
		ST_START_A  = 9'h004,
		ST_START_B  = 9'h008,
		ST_BIT_LO   = 9'h010,
		ST_BIT_HI   = 9'h020,
		ST_STOP_LO  = 9'h040,
		ST_STOP_HI  = 9'h080,
		ST_STOP_END = 9'h100
	} imc_state_t;

	typedef enum logic [2:0] {
		PH_SBYTE = 3'h1,
		PH_ADDR  = 3'h2,
		PH_DATA  = 3'h4
	} imc_phase_t;

	typedef struct packed {
		logic sclOut;
		logic sclOeN;
		logic sdaOut;
		logic sdaOeN;
	} imc_pad_out_t;

	typedef struct packed {
		logic [1:0]  sclSync;
		logic [1:0]  sdaSync;
		logic        rsv6;
		logic        restartEn;
		logic [1:0]  speed;
		logic        masterEn;
		logic [6:0]  tar;
		logic [7:0]  rxData;
		logic        pend;
		logic        pendRead;
		logic        pendSbyte;
		logic [7:0]  pendData;
		logic        curRead;
		logic [7:0]  curData;
		logic [15:0] hcnt;
		logic        ifEn;
		logic [15:0] div;
		logic [15:0] divCnt;
		logic [6:0]  status;
		logic [6:0]  intEn;
		imc_state_t  st;
		imc_phase_t  phase;
		logic [16:0] cnt;
		logic [8:0]  shift;
		logic [3:0]  bitIdx;
		logic        sclLow;
		logic        sdaLow;
		logic [31:0] prdata;
	} imc_core_state_t;

endpackage

/* File: bench/imc_i2c_slave.sv */
// Purpose: behavioural two-wire target for the master bench
// Assumes: open drain wires with pull-ups, resolved by the bench
// Notes:   never stretches the clock; acks only its own address
`timescale 1ns/100ps
`default_nettype none

module imc_i2c_slave #(
	parameter logic [6:0] ADDR  = 7'h52,
	parameter logic [7:0] RDATA = 8'h3c
)(
	// wires
	input  wire logic       scl,
	input  wire logic       sda,
	output var  logic       sdaOeN,
	// observation
	output var  int         starts,
	output var  int         stops,
	output var  logic [7:0] addrByte,
	output var  logic [7:0] dataByte
);
	logic       sclQ = 1'h1;
	logic       inAddr = 1'h0;
	logic       match = 1'h0;
	logic       rdMode = 1'h0;
	logic [7:0] shift = 8'h00;
	int         bitCnt = 0;

	initial
	begin
		sdaOeN = 1'h1;
		starts = 0;
		stops = 0;
		addrByte = 8'h00;
		dataByte = 8'h00;
	end

	// both pins may move in one step; settle first so a clock fall
	// with a data change is never taken for a start or stop
	always @(scl, sda)
	begin
		#1;
		if (scl && sclQ)
		begin
			sdaOeN = 1'h1;
			if (!sda)
			begin
				starts++;
				bitCnt = 0;
				inAddr = 1'h1;
			end
			else
				stops++;
		end
		else if (scl && bitCnt < 9)
		begin
			shift = {shift[6:0], sda};
			bitCnt++;
		end
		else if (!scl && sclQ)
		begin
			if (bitCnt == 8 && inAddr)
			begin
				addrByte = shift;
				match = (shift[7:1] == ADDR);
				rdMode = shift[0];
				sdaOeN = !match;
			end
			else if (bitCnt == 8)
			begin
				if (!rdMode)
					dataByte = shift;
				sdaOeN = rdMode || !match;
			end
			else if (bitCnt == 9)
			begin
				bitCnt = 0;
				inAddr = 1'h0;
				// a master nack ends the read: let go so the stop can be seen
				sdaOeN = (match && rdMode && !shift[0]) ? RDATA[7] : 1'h1;
			end
			else if (bitCnt > 0 && !inAddr && match && rdMode)
				sdaOeN = RDATA[7 - bitCnt];
		end
		sclQ = scl;
	end
endmodule
`default_nettype wire

/* File: bench/tb_imc_core.sv */
// Purpose: self-checking bench of the two-wire master
// Assumes: zero-wait apb, divider left at 0 so T is one clock
// Notes:   transfers run at standard speed with a short high count
`timescale 1ns/100ps
`default_nettype none
`include "imc_regs.svh"

module tb_imc_core
	import imc_pkg::*;
;
	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [31:0] wd;
		logic [31:0] exp;
	} imc_row_t;

	// ------
	// signals
	// ------
	logic         clock;
	logic         rstn;
	logic         psel;
	logic         penable;
	logic         pwrite;
	logic [15:0]  paddr;
	logic [31:0]  pwdata;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic         irq;
	imc_pad_out_t pads;
	logic         slvOeN;
	int           starts;
	int           stops;
	logic [7:0]   addrByte;
	logic [7:0]   dataByte;
	logic [31:0]  r;
	logic         e;
	int           bad_count = 0;
	int           check_count = 0;
	int           highRun = 0;
	int           lastHigh = 0;
	int           s0;
	int           p0;
	wire logic    scl = pads.sclOeN;
	wire logic    sda = pads.sdaOeN & slvOeN;

	imc_row_t rows [14] = '{
		'{1'h0, `IMC_CTRL_OFS, 32'h0, 32'h65},
		'{1'h0, `IMC_TAR_OFS, 32'h0, 32'h55},
		'{1'h0, `IMC_DATA_OFS, 32'h0, 32'h0},
		'{1'h0, `IMC_HCNT_OFS, 32'h0, 32'h64},
		'{1'h1, `IMC_HCNT_OFS, 32'h5, 32'h6},
		'{1'h1, `IMC_HCNT_OFS, 32'h2, 32'h6},
		'{1'h1, `IMC_TAR_OFS, 32'h3d2, 32'h52},
		'{1'h1, `IMC_CTRL_OFS, 32'h63, 32'h63},
		'{1'h1, `IMC_IFEN_OFS, 32'h1, 32'h1},
		'{1'h1, `IMC_CTRL_OFS, 32'h40, 32'h63},
		'{1'h1, `IMC_TAR_OFS, 32'h11, 32'h52},
		'{1'h1, `IMC_HCNT_OFS, 32'h30, 32'h6},
		'{1'h1, `IMC_INTEN_OFS, 32'h43, 32'h43},
		'{1'h0, `IMC_RSVD_OFS, 32'h0, 32'h0}
	};

	imc_core u_dut (
		.clock   (clock),
		.rstn    (rstn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.irq     (irq),
		.sclIn   (scl),
		.sdaIn   (sda),
		.pads    (pads)
	);

	imc_i2c_slave u_slave (
		.scl      (scl),
		.sda      (sda),
		.sdaOeN   (slvOeN),
		.starts   (starts),
		.stops    (stops),
		.addrByte (addrByte),
		.dataByte (dataByte)
	);

	initial
	begin
		clock = 1'h0;
		forever #25 clock = ~clock;
	end

	// width of the last finished scl high phase, in clocks
	always @(posedge clock)
	begin
		highRun <= scl ? highRun + 1 : 0;
		if (!scl && highRun != 0)
			lastHigh <= highRun;
	end

	// ------
	// tasks
	// ------
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] want, input string m);
		check_count++;
		if (got !== want)
		begin
			bad_count++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, got, want);
		end
	endtask

	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 20)
		begin
			bad_count++;
			test_done();
		end
	endtask

	// polls pending and busy bits under a bound
	task automatic waitIf(input logic [31:0] mask);
		int n;
		n = 0;
		do
		begin
			apb(1'h0, `IMC_IFEN_OFS, 32'h0);
			n++;
		end
		while ((r & mask) !== 32'h0 && n < 3000);
		if (n >= 3000)
		begin
			bad_count++;
			test_done();
		end
	endtask

	// write then read, second queued while the first runs
	task automatic pair();
		s0 = starts;
		p0 = stops;
		apb(1'h1, `IMC_DATA_OFS, 32'h0a5);
		waitIf(32'h2);
		apb(1'h1, `IMC_DATA_OFS, 32'h100);
		waitIf(32'h6);
	endtask

	initial
	begin
		repeat (60000) @(posedge clock);
		bad_count++;
		test_done();
	end

	// ------
	// sequence
	// ------
	initial
	begin
		rstn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 16'h0;
		pwdata = 32'h0;
		repeat (5) @(posedge clock);
		rstn <= 1'h1;
		foreach (rows[i])
		begin
			if (rows[i].wr)
				apb(1'h1, rows[i].addr, rows[i].wd);
			apb(1'h0, rows[i].addr, 32'h0);
			chk(r, rows[i].exp, "register row");
		end
		apb(1'h1, `IMC_DATA_OFS, 32'h0a5);
		waitIf(32'h6);
		chk({24'h0, addrByte}, 32'ha4, "write address");
		chk({24'h0, dataByte}, 32'ha5, "write byte");
		// high count 6 plus 8, plus two clocks of pin synchroniser
		chk(32'(lastHigh), 32'(6 + 8 + 2), "scl high width");
		apb(1'h0, `IMC_STAT_OFS, 32'h0);
		chk(r & 32'h2, 32'h2, "done flag");
		chk({31'h0, irq}, 32'h1, "irq raised");
		apb(1'h1, `IMC_CLR_OFS, 32'h43);
		@(posedge clock);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		apb(1'h1, `IMC_DATA_OFS, 32'h100);
		waitIf(32'h6);
		apb(1'h0, `IMC_DATA_OFS, 32'h0);
		chk(r & 32'hff, 32'h3c, "read byte");
		chk({24'h0, addrByte}, 32'ha5, "read address");
		pair();
		chk(32'(starts - s0), 32'h2, "repeated start");
		chk(32'(stops - p0), 32'h1, "one stop");
		s0 = starts;
		apb(1'h1, `IMC_DATA_OFS, 32'h4a5);
		waitIf(32'h6);
		chk(32'(starts - s0), 32'h2, "start byte then restart");
		chk({24'h0, addrByte}, 32'ha4, "address after start byte");
		apb(1'h1, `IMC_IFEN_OFS, 32'h0);
		apb(1'h1, `IMC_CTRL_OFS, 32'h43);
		apb(1'h1, `IMC_IFEN_OFS, 32'h1);
		pair();
		chk(32'(starts - s0), 32'h2, "split starts");
		chk(32'(stops - p0), 32'h2, "split stops");
		s0 = starts;
		apb(1'h1, `IMC_CLR_OFS, 32'h43);
		apb(1'h1, `IMC_DATA_OFS, 32'h400);
		waitIf(32'h6);
		apb(1'h0, `IMC_STAT_OFS, 32'h0);
		chk(r & 32'h40, 32'h40, "abort flag");
		chk(32'(starts - s0), 32'h0, "no start byte");
		chk({31'h0, irq}, 32'h1, "abort irq");
		apb(1'h0, 16'h3900, 32'h0);
		chk({31'h0, e}, 32'h1, "unmapped error");
		chk(r, 32'h0, "unmapped data");
		apb(1'h1, `IMC_DATA_OFS, 32'h0a5);
		repeat (300) @(posedge clock);
		rstn <= 1'h0;
		repeat (2) @(posedge clock);
		rstn <= 1'h1;
		@(posedge clock);
		chk({27'h0, pready, pads.sclOut, pads.sdaOut, pads.sclOeN, pads.sdaOeN}, 32'h13,
			"pins released");
		chk({31'h0, irq}, 32'h0, "irq after reset");
		apb(1'h0, `IMC_CTRL_OFS, 32'h0);
		chk(r, 32'h65, "control after reset");
		test_done();
	end
endmodule
`default_nettype wire
